// [rtl/rmic_defs.svh]
// Constants of the retain memory init controller: layout, offsets, fields, resets, timing
`ifndef RMIC_DEFS_SVH
`define RMIC_DEFS_SVH

// ----------------------------------------------------------------------------
// Memory geometry and area boundaries (word addresses)
// ----------------------------------------------------------------------------
`define RMIC_ADDR_W        5
`define RMIC_DATA_W        16
`define RMIC_WORDS         32
`define RMIC_INIT_BASE     5'h08
`define RMIC_RET_BASE      5'h0c
`define RMIC_RETINIT_BASE  5'h10
`define RMIC_M_BASE        5'h14
`define RMIC_KLN_BASE      5'h1c
`define RMIC_FLASH_BASE    5'h1e
`define RMIC_LAST_ADDR     5'h1f

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define RMIC_REG_CTRL      12'h000
`define RMIC_REG_CMD       12'h004
`define RMIC_REG_STATUS    12'h008
`define RMIC_REG_MADDR     12'h00c
`define RMIC_REG_MDATA     12'h010
`define RMIC_REG_IDATA     12'h014

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RMIC_CTRL_WARM     0
`define RMIC_CTRL_MRET_LSB 8
`define RMIC_CTRL_MRET_MSB 11
`define RMIC_CMD_OVERALL   0
`define RMIC_CMD_DELETE    1
`define RMIC_CMD_RESET     2
`define RMIC_STAT_RUN      0
`define RMIC_STAT_BUSY     1
`define RMIC_STAT_BLINK    2
`define RMIC_STAT_OP_LSB   4
`define RMIC_STAT_OP_MSB   6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RMIC_WARM_RST      1'h0
`define RMIC_MRET_RST      4'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RMIC_CLK_KHZ       40000
`define RMIC_HOLD_MS       3000
`define RMIC_BLINK_MS      250
`define RMIC_LEDS          6

`endif

// [rtl/rmic_pkg.sv]
// Types of the retain memory init controller
package rmic_pkg;

    // ------------------------------------------------------------------------
    // Sequencer state, operations, area classes and per-word actions
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SWEEP = 2'b10
    } rmic_state_t;

    typedef enum logic [2:0] {
        OP_NONE       = 3'h0,
        OP_START_COLD = 3'h1,
        OP_START_WARM = 3'h2,
        OP_RESET_KEEP = 3'h3,
        OP_OVERALL    = 3'h4,
        OP_DCLR       = 3'h5,
        OP_DCLR_LONG  = 3'h6,
        OP_DELETE     = 3'h7
    } rmic_op_t;

    typedef enum logic [2:0] {
        AR_DEFAULT = 3'h0,
        AR_INIT    = 3'h1,
        AR_RETAIN  = 3'h2,
        AR_RETINIT = 3'h3,
        AR_MRET    = 3'h4,
        AR_KLN     = 3'h5,
        AR_FLASH   = 3'h6
    } rmic_area_t;

    typedef enum logic [1:0] {
        ACT_KEEP = 2'h0,
        ACT_ZERO = 2'h1,
        ACT_INIT = 2'h2
    } rmic_act_t;

    typedef struct packed {
        rmic_op_t   op;
        logic [4:0] addr;
    } rmic_job_t;

endpackage

// [rtl/rmic_top.sv]
// Retain memory init controller: clears, loads or keeps data areas on restart, reset and clear
`timescale 1ns/1ps
`include "rmic_defs.svh"

module rmic_top #(
    parameter int unsigned HOLD_CYCLES  = `RMIC_HOLD_MS * `RMIC_CLK_KHZ,
    parameter int unsigned BLINK_CYCLES = `RMIC_BLINK_MS * `RMIC_CLK_KHZ
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    input  wire logic                   run_switch,
    input  wire logic                   reset_switch_n,
    input  wire logic                   data_clear_switch,
    output logic                        running,
    output logic                        busy,
    output logic [`RMIC_LEDS-1:0]       led_flash
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] sat_inc(input logic [31:0] cnt, input logic [31:0] lim);
        sat_inc = (cnt >= lim) ? lim : cnt + 32'h0000_0001;
    endfunction

    // Area class of a word; only the first mret_n words of M are retained
    function automatic rmic_pkg::rmic_area_t area_of(input logic [4:0] a, input logic [3:0] mret_n);
        logic [4:0] m_off;
        m_off = a - `RMIC_M_BASE;
        if (a >= `RMIC_FLASH_BASE)
            area_of = rmic_pkg::AR_FLASH;
        else if (a >= `RMIC_KLN_BASE)
            area_of = rmic_pkg::AR_KLN;
        else if (a >= `RMIC_M_BASE)
            area_of = ({1'h0, m_off} < {1'h0, mret_n}) ? rmic_pkg::AR_MRET : rmic_pkg::AR_DEFAULT;
        else if (a >= `RMIC_RETINIT_BASE)
            area_of = rmic_pkg::AR_RETINIT;
        else if (a >= `RMIC_RET_BASE)
            area_of = rmic_pkg::AR_RETAIN;
        else if (a >= `RMIC_INIT_BASE)
            area_of = rmic_pkg::AR_INIT;
        else
            area_of = rmic_pkg::AR_DEFAULT;
    endfunction

    function automatic rmic_pkg::rmic_act_t act_of(input rmic_pkg::rmic_op_t op, input rmic_pkg::rmic_area_t ar);
        act_of = rmic_pkg::ACT_KEEP;
        unique case (op)
            rmic_pkg::OP_START_COLD: begin
                if (ar == rmic_pkg::AR_INIT || ar == rmic_pkg::AR_RETINIT)
                    act_of = rmic_pkg::ACT_INIT;
                else if (ar == rmic_pkg::AR_DEFAULT || ar == rmic_pkg::AR_RETAIN || ar == rmic_pkg::AR_MRET)
                    act_of = rmic_pkg::ACT_ZERO;
            end
            rmic_pkg::OP_START_WARM: begin
                if (ar == rmic_pkg::AR_INIT)
                    act_of = rmic_pkg::ACT_INIT;
                else if (ar == rmic_pkg::AR_DEFAULT)
                    act_of = rmic_pkg::ACT_ZERO;
            end
            rmic_pkg::OP_OVERALL, rmic_pkg::OP_DCLR: begin
                if (ar == rmic_pkg::AR_DEFAULT || ar == rmic_pkg::AR_RETAIN || ar == rmic_pkg::AR_MRET ||
                    ar == rmic_pkg::AR_RETINIT)
                    act_of = rmic_pkg::ACT_ZERO;
            end
            rmic_pkg::OP_DCLR_LONG: begin
                if (ar != rmic_pkg::AR_KLN && ar != rmic_pkg::AR_INIT)
                    act_of = rmic_pkg::ACT_ZERO;
            end
            rmic_pkg::OP_DELETE: begin
                if (ar != rmic_pkg::AR_FLASH)
                    act_of = rmic_pkg::ACT_ZERO;
            end
            rmic_pkg::OP_NONE, rmic_pkg::OP_RESET_KEEP: act_of = rmic_pkg::ACT_KEEP;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    // Battery-backed and flash-backed words share one array here; the area
    // class alone decides which survive, so the split is a placement matter.
    logic [`RMIC_DATA_W-1:0]  mem      [`RMIC_WORDS];
    logic [`RMIC_DATA_W-1:0]  init_val [`RMIC_WORDS];

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    rmic_pkg::rmic_state_t    state;
    rmic_pkg::rmic_job_t      job;
    rmic_pkg::rmic_op_t       last_op;
    logic                     warm;
    logic [3:0]               mret_n;
    logic [4:0]               maddr;
    logic [2:0]               run_sync;
    logic [2:0]               rst_sync;
    logic [2:0]               dclr_sync;
    logic                     rst_prev;
    logic                     dclr_prev;
    logic [31:0]              rst_cnt;
    logic [31:0]              dclr_cnt;
    logic [31:0]              blink_cnt;
    logic                     blink_phase;

    // ------------------------------------------------------------------------
    // Switch inputs
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_sync  <= 3'h0;
            rst_sync  <= 3'h0;
            dclr_sync <= 3'h0;
        end else begin
            run_sync  <= {run_sync[1:0], run_switch};
            rst_sync  <= {rst_sync[1:0], ~reset_switch_n};
            dclr_sync <= {dclr_sync[1:0], data_clear_switch};
        end
    end

    wire run_s       = run_sync[1];
    wire rst_s       = rst_sync[1];
    wire dclr_eff    = dclr_sync[1] & ~running;
    wire rst_long    = (rst_cnt == HOLD_CYCLES);
    wire dclr_long   = (dclr_cnt == HOLD_CYCLES);
    wire rst_rel     = rst_prev & ~rst_s;
    wire dclr_rel    = dclr_prev & ~dclr_eff & ~running;
    wire blink_tick  = (blink_cnt >= BLINK_CYCLES - 32'h0000_0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_prev  <= 1'h0;
            dclr_prev <= 1'h0;
            rst_cnt   <= 32'h0000_0000;
            dclr_cnt  <= 32'h0000_0000;
        end else begin
            rst_prev  <= rst_s;
            dclr_prev <= dclr_eff;
            rst_cnt   <= rst_s ? sat_inc(rst_cnt, HOLD_CYCLES) : 32'h0000_0000;
            dclr_cnt  <= dclr_eff ? sat_inc(dclr_cnt, HOLD_CYCLES) : 32'h0000_0000;
        end
    end

    // Blink runs only while a long data-clear press is held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt   <= 32'h0000_0000;
            blink_phase <= 1'h0;
            led_flash   <= '0;
        end else begin
            blink_cnt   <= (blink_tick || !dclr_long) ? 32'h0000_0000 : blink_cnt + 32'h0000_0001;
            blink_phase <= dclr_long ? (blink_phase ^ blink_tick) : 1'h0;
            led_flash   <= {`RMIC_LEDS{dclr_long & dclr_eff & ~blink_phase}};
        end
    end

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire setup     = psel & ~penable;
    wire wr_done   = psel & penable & pready & pwrite;
    wire sel_ctrl  = (paddr == `RMIC_REG_CTRL);
    wire sel_cmd   = (paddr == `RMIC_REG_CMD);
    wire sel_stat  = (paddr == `RMIC_REG_STATUS);
    wire sel_maddr = (paddr == `RMIC_REG_MADDR);
    wire sel_mdata = (paddr == `RMIC_REG_MDATA);
    wire sel_idata = (paddr == `RMIC_REG_IDATA);
    wire mapped    = sel_ctrl | sel_cmd | sel_stat | sel_maddr | sel_mdata | sel_idata;
    wire idle      = (state == rmic_pkg::ST_IDLE);

    wire cmd_overall = wr_done & sel_cmd & pwdata[`RMIC_CMD_OVERALL];
    wire cmd_delete  = wr_done & sel_cmd & pwdata[`RMIC_CMD_DELETE] & ~running;
    wire cmd_reset   = wr_done & sel_cmd & pwdata[`RMIC_CMD_RESET];

    wire [31:0] rd_word =
        sel_ctrl  ? {20'h0_0000, mret_n, 7'h00, warm} :
        sel_stat  ? {25'h000_0000, last_op, 1'h0, dclr_long, busy, running} :
        sel_maddr ? {27'h000_0000, maddr} :
        sel_mdata ? {16'h0000, mem[maddr]} :
        sel_idata ? {16'h0000, init_val[maddr]} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'h0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'h0;
        end else begin
            pready  <= setup;
            prdata  <= (setup && !pwrite) ? rd_word : prdata;
            pslverr <= setup & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm   <= `RMIC_WARM_RST;
            mret_n <= `RMIC_MRET_RST;
            maddr  <= 5'h00;
        end else if (wr_done) begin
            if (sel_ctrl) begin
                warm   <= pwdata[`RMIC_CTRL_WARM];
                mret_n <= pwdata[`RMIC_CTRL_MRET_MSB:`RMIC_CTRL_MRET_LSB];
            end
            if (sel_maddr)
                maddr <= pwdata[4:0];
        end
    end

    // ------------------------------------------------------------------------
    // Operation selection
    // ------------------------------------------------------------------------
    // Events that arrive while a sweep runs are dropped; tool commands and switch
    // releases are one-cycle pulses, so both can be lost this way; run is a level.
    wire start_req = run_s & ~running;
    wire any_reset = (rst_rel & ~rst_long) | cmd_reset;

    rmic_pkg::rmic_op_t next_op;
    assign next_op =
        cmd_delete                     ? rmic_pkg::OP_DELETE     :
        (cmd_overall | (rst_rel & rst_long)) ? rmic_pkg::OP_OVERALL :
        (dclr_rel & dclr_long)         ? rmic_pkg::OP_DCLR_LONG  :
        dclr_rel                       ? rmic_pkg::OP_DCLR       :
        (any_reset & ~running)         ? rmic_pkg::OP_RESET_KEEP :
        (any_reset & ~warm)            ? rmic_pkg::OP_START_COLD :
        any_reset                      ? rmic_pkg::OP_START_WARM :
        (start_req & ~warm)            ? rmic_pkg::OP_START_COLD :
        start_req                      ? rmic_pkg::OP_START_WARM :
                                         rmic_pkg::OP_NONE;

    wire job_start  = idle & (next_op != rmic_pkg::OP_NONE);
    wire sweep_last = (job.addr == `RMIC_LAST_ADDR);
    wire is_start   = (job.op == rmic_pkg::OP_START_COLD) | (job.op == rmic_pkg::OP_START_WARM);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= rmic_pkg::ST_IDLE;
            job     <= '{op: rmic_pkg::OP_NONE, addr: 5'h00};
            last_op <= rmic_pkg::OP_NONE;
            running <= 1'h0;
            busy    <= 1'h0;
        end else begin
            unique case (state)
                rmic_pkg::ST_IDLE: begin
                    if (job_start) begin
                        state   <= rmic_pkg::ST_SWEEP;
                        job     <= '{op: next_op, addr: 5'h00};
                        last_op <= next_op;
                        busy    <= 1'h1;
                    end else if (!run_s) begin
                        running <= 1'h0;
                    end
                end
                rmic_pkg::ST_SWEEP: begin
                    job.addr <= job.addr + 5'h01;
                    if (sweep_last) begin
                        state <= rmic_pkg::ST_IDLE;
                        busy  <= 1'h0;
                        if (is_start)
                            running <= run_s;
                    end
                end
                default: begin
                    state <= rmic_pkg::ST_IDLE;
                    busy  <= 1'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Memory update: sweep has priority; MDATA writes only while idle, IDATA writes at any time
    // ------------------------------------------------------------------------
    rmic_pkg::rmic_act_t cur_act;
    assign cur_act = act_of(job.op, area_of(job.addr, mret_n));

    wire sweeping = (state == rmic_pkg::ST_SWEEP);

    always_ff @(posedge pclk) begin
        if (sweeping) begin
            if (cur_act == rmic_pkg::ACT_ZERO)
                mem[job.addr] <= '0;
            else if (cur_act == rmic_pkg::ACT_INIT)
                mem[job.addr] <= init_val[job.addr];
        end else if (wr_done && sel_mdata) begin
            mem[maddr] <= pwdata[`RMIC_DATA_W-1:0];
        end
        if (wr_done && sel_idata)
            init_val[maddr] <= pwdata[`RMIC_DATA_W-1:0];
    end

endmodule

// [sim/rmic_top_asserts.sv]
// Concurrent checks on the ports of the retain memory init controller
`timescale 1ns/1ps
`include "rmic_defs.svh"

module rmic_top_asserts #(
    parameter int unsigned HOLD_CYCLES  = 20,
    parameter int unsigned BLINK_CYCLES = 4
) (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic                   pready,
    input wire logic [31:0]            prdata,
    input wire logic                   pslverr,
    input wire logic                   run_switch,
    input wire logic                   reset_switch_n,
    input wire logic                   data_clear_switch,
    input wire logic                   running,
    input wire logic                   busy,
    input wire logic [`RMIC_LEDS-1:0]  led_flash
);
    localparam int SWEEP = 32;
    logic [31:0] busy_cnt;
    logic [31:0] clr_cnt;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt <= 32'h0;
            clr_cnt  <= 32'h0;
        end else begin
            busy_cnt <= busy ? busy_cnt + 32'h1 : 32'h0;
            // Saturates so a stuck switch cannot wrap the count
            clr_cnt  <= !data_clear_switch ? 32'h0 : (clr_cnt > HOLD_CYCLES + 8 ? clr_cnt : clr_cnt + 32'h1);
        end
    end

    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    sweep_length_a: assert property ($fell(busy) |-> busy_cnt == SWEEP)
        else $error("sweep length wrong");
    run_at_end_a: assert property ($rose(running) |-> $fell(busy))
        else $error("running rose outside sweep end");
    run_off_a: assert property ($fell(run_switch) && !busy |-> ##[1:5] !running)
        else $error("running did not drop");
    clr_ignored_a: assert property ($fell(data_clear_switch) && running && run_switch && !busy |-> !busy[*6])
        else $error("data clear acted while running");
    clr_acts_a: assert property ($fell(data_clear_switch) && !running && !busy |-> ##[1:6] busy)
        else $error("data clear did not start sweep");
    led_stopped_a: assert property (led_flash != 6'h00 |-> !running)
        else $error("leds lit while running");
    led_hold_a: assert property ($rose(led_flash[0]) |-> clr_cnt >= HOLD_CYCLES && led_flash == 6'h3f)
        else $error("leds blinked before hold time");
    delete_sweep_a: assert property (psel && penable && pready && pwrite && paddr == `RMIC_REG_CMD
        && pwdata[`RMIC_CMD_DELETE] && !running && !busy |-> ##[1:3] busy)
        else $error("delete did not start sweep");
    ready_timing_a: assert property (psel && !penable |=> pready && penable)
        else $error("pready not in access cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
endmodule

bind rmic_top rmic_top_asserts #(.HOLD_CYCLES(HOLD_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) i_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .run_switch(run_switch),
    .reset_switch_n(reset_switch_n), .data_clear_switch(data_clear_switch), .running(running),
    .busy(busy), .led_flash(led_flash));

// [sim/rmic_panel.sv]
// Front panel model: mode switch, reset switch and data clear switch
`timescale 1ns/1ps

module rmic_panel (
    input  wire logic  pclk,
    output logic       run_switch,
    output logic       reset_switch_n,
    output logic       data_clear_switch
);
    initial begin
        run_switch        = 1'b0;
        reset_switch_n    = 1'b1;
        data_clear_switch = 1'b0;
    end

    // ------------------------------------------------------------------------
    // Operator actions; reset and clear pushes are held for a chosen number of cycles
    // ------------------------------------------------------------------------
    task set_run(input logic v);
        @(posedge pclk);
        run_switch <= v;
    endtask

    task push_reset(input int n);
        @(posedge pclk);
        reset_switch_n <= 1'b0;
        repeat (n) @(posedge pclk);
        reset_switch_n <= 1'b1;
    endtask

    task push_clear(input int n);
        @(posedge pclk);
        data_clear_switch <= 1'b1;
        repeat (n) @(posedge pclk);
        data_clear_switch <= 1'b0;
    endtask
endmodule

// [sim/tb_retain_memory_init_control.sv]
// Testbench of the retain memory init controller
`timescale 1ns/1ps
`include "rmic_defs.svh"

module tb_retain_memory_init_control;
    localparam logic [1:0]  ak = rmic_pkg::ACT_KEEP;
    localparam logic [1:0]  az = rmic_pkg::ACT_ZERO;
    localparam logic [1:0]  ai = rmic_pkg::ACT_INIT;
    // Order of areas: flash, kln, m, retain-init, retain, init, default
    localparam logic [13:0] act_cold = {ak, ak, az, ai, az, ai, az};
    localparam logic [13:0] act_warm = {ak, ak, ak, ak, ak, ai, az};
    localparam logic [13:0] act_keep = {ak, ak, ak, ak, ak, ak, ak};
    localparam logic [13:0] act_clr  = {ak, ak, az, az, az, ak, az};
    localparam logic [13:0] act_clrl = {az, ak, az, az, az, ak, az};
    localparam logic [13:0] act_del  = {ak, az, az, az, az, az, az};

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, running, busy;
    logic        run_switch, reset_switch_n, data_clear_switch, seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [5:0]  led_flash;
    int          num_errors, num_checks, cycles;

    rmic_top #(.HOLD_CYCLES(20), .BLINK_CYCLES(4)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .run_switch(run_switch),
        .reset_switch_n(reset_switch_n), .data_clear_switch(data_clear_switch), .running(running),
        .busy(busy), .led_flash(led_flash));
    rmic_panel i_panel (.pclk(pclk), .run_switch(run_switch), .reset_switch_n(reset_switch_n),
        .data_clear_switch(data_clear_switch));

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] pat(int i);
        return 32'h0000_5000 + 32'(i);
    endfunction
    function automatic logic [31:0] ini(int i);
        return 32'h0000_a000 + 32'(i);
    endfunction
    function automatic int area_of(int i);
        if (i < `RMIC_INIT_BASE) return 0;
        if (i < `RMIC_RET_BASE) return 1;
        if (i < `RMIC_RETINIT_BASE) return 2;
        if (i < `RMIC_M_BASE) return 3;
        if (i < `RMIC_KLN_BASE) return (i < `RMIC_M_BASE + 4) ? 4 : 0;
        if (i < `RMIC_FLASH_BASE) return 5;
        return 6;
    endfunction

    task stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Holds the request until pready is sampled high
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdat = prdata;
        seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // exp 2 means a sweep may or may not follow
    task wait_op(input int exp);
        int n;
        logic saw;
        saw = 1'b0;
        repeat (8) begin
            @(posedge pclk);
            if (busy === 1'b1) saw = 1'b1;
        end
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        if (exp < 2) chk("busy seen", {31'h0, saw}, 32'(exp));
    endtask

    task fill;
        for (int i = 0; i < 32; i++) begin
            xfer(1'b1, `RMIC_REG_MADDR, 32'(i));
            xfer(1'b1, `RMIC_REG_MDATA, pat(i));
        end
    endtask

    task check_mem(input logic [13:0] acts);
        logic [31:0] e;
        for (int i = 0; i < 32; i++) begin
            xfer(1'b1, `RMIC_REG_MADDR, 32'(i));
            xfer(1'b0, `RMIC_REG_MDATA, 32'h0);
            case (acts[2*area_of(i) +: 2])
                az: e = 32'h0;
                ai: e = ini(i);
                default: e = pat(i);
            endcase
            chk("memory word", rdat, e);
        end
    endtask

    // ------------------------------------------------------------------------
    // Clock, timeout and test sequence
    // ------------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            stop_test;
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, `RMIC_REG_CTRL, 32'h0);
        chk("ctrl reset", rdat, 32'h0);
        xfer(1'b1, 12'h0fc, 32'h1);
        chk("unmapped error", {31'h0, seen}, 32'h1);
        for (int i = 0; i < 32; i++) begin
            xfer(1'b1, `RMIC_REG_MADDR, 32'(i));
            xfer(1'b1, `RMIC_REG_IDATA, ini(i));
        end
        $display("test reset values done");
        xfer(1'b1, `RMIC_REG_CTRL, 32'h0000_0400);
        fill;
        i_panel.set_run(1'b1);
        wait_op(1);
        chk("running", {31'h0, running}, 32'h1);
        check_mem(act_cold);
        fill;
        i_panel.push_reset(4);
        wait_op(1);
        check_mem(act_cold);
        i_panel.push_clear(4);
        wait_op(0);
        xfer(1'b1, `RMIC_REG_CMD, 32'h0000_0002);
        wait_op(0);
        i_panel.set_run(1'b0);
        repeat (6) @(posedge pclk);
        chk("stopped", {31'h0, running}, 32'h0);
        $display("test cold restart done");
        xfer(1'b1, `RMIC_REG_CTRL, 32'h0000_0401);
        fill;
        i_panel.set_run(1'b1);
        wait_op(1);
        check_mem(act_warm);
        fill;
        i_panel.push_reset(4);
        wait_op(2);
        check_mem(act_warm);
        i_panel.set_run(1'b0);
        repeat (6) @(posedge pclk);
        $display("test warm restart done");
        fill;
        i_panel.push_reset(4);
        wait_op(2);
        check_mem(act_keep);
        i_panel.push_clear(4);
        wait_op(1);
        check_mem(act_clr);
        fill;
        seen = 1'b0;
        fork
            i_panel.push_clear(40);
            repeat (40) @(posedge pclk) if (led_flash === 6'h3f) seen = 1'b1;
        join
        chk("leds blink", {31'h0, seen}, 32'h1);
        wait_op(1);
        check_mem(act_clrl);
        $display("test data clear done");
        fill;
        i_panel.push_reset(40);
        wait_op(1);
        check_mem(act_clr);
        fill;
        xfer(1'b1, `RMIC_REG_CMD, 32'h0000_0002);
        wait_op(1);
        check_mem(act_del);
        xfer(1'b0, `RMIC_REG_STATUS, 32'h0);
        chk("last op", {29'h0, rdat[6:4]}, 32'h7);
        fill;
        xfer(1'b1, `RMIC_REG_CMD, 32'h0000_0001);
        wait_op(1);
        check_mem(act_clr);
        xfer(1'b1, `RMIC_REG_CMD, 32'h0000_0004);
        wait_op(1);
        check_mem(act_clr);
        $display("test overall reset and delete done");
        stop_test;
    end
endmodule
